// file: dv/pulse_src.sv
/*
  Behavioural pulse-train positioner: emits cnt pulses, two cycles high
  and two low each, with a held direction level.
  Assumes go is a one-cycle request given while busy is low.
*/
`timescale 1ns/1ps
module pulse_src (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic go,
  input wire logic dir,
  input wire logic [9:0] cnt,
  output logic pulse,
  output logic dir_o,
  output logic busy
);
  logic [9:0] left;
  logic [1:0] ph;
  assign busy = left != 10'h000;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      left <= 10'h000;
      ph <= 2'h0;
      pulse <= 1'b0;
      dir_o <= 1'b0;
    end else if (go && !busy) begin
      left <= cnt;
      ph <= 2'h0;
      dir_o <= dir;
    end else if (busy) begin
      pulse <= ~ph[1];
      ph <= ph + 2'h1;
      if (ph == 2'h3) begin
        left <= left - 10'h001;
      end
    end
  end
endmodule

// file: dv/servo_position_loop_tuning_tb.sv
/*
  Self-checking bench for pos_loop: APB register tasks and two pulse
  sources on the command and feedback pins.
  Assumes the parameter header is on the include path.
*/
`timescale 1ns/1ps
`include "pos_loop_params.svh"
module servo_position_loop_tuning_tb;
  import pos_loop_pkg::*;
  logic clk_sys, nrst, psel, penable, pwrite, heavy_torque;
  logic [11:0] paddr;
  word_t pwdata, prdata, rdv;
  logic pready, pslverr, rerr, in_position, overflow_err, comp_gain_err;
  logic signed [15:0] speed_cmd;
  logic [10:0] speed_gain_eff;
  logic irq, cgo, fgo, sdir, cmd_pulse, cmd_dir, fb_pulse, fb_dir;
  logic cbusy, fbusy;
  logic [9:0] scnt;
  int err_count, tests_run, cyc, spd_hits, hits0;
  pos_loop #(.TICK_CYC(2)) uut (.clk_sys(clk_sys), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmd_pulse(cmd_pulse), .cmd_dir(cmd_dir),
    .fb_pulse(fb_pulse), .fb_dir(fb_dir), .heavy_torque(heavy_torque),
    .in_position(in_position), .overflow_err(overflow_err),
    .comp_gain_err(comp_gain_err), .speed_cmd(speed_cmd),
    .speed_gain_eff(speed_gain_eff), .irq(irq));
  pulse_src csrc (.clk_sys(clk_sys), .nrst(nrst), .go(cgo), .dir(sdir),
    .cnt(scnt), .pulse(cmd_pulse), .dir_o(cmd_dir), .busy(cbusy));
  pulse_src fsrc (.clk_sys(clk_sys), .nrst(nrst), .go(fgo), .dir(sdir),
    .cnt(scnt), .pulse(fb_pulse), .dir_o(fb_dir), .busy(fbusy));
  localparam logic [11:0] ra [9] = '{`ADDR_WINDOW, `ADDR_OVF_LVL,
    `ADDR_BIAS, `ADDR_FF_AMT, `ADDR_COMP_GAIN, `ADDR_SPD_GAIN,
    `ADDR_SPD_INTEG, `ADDR_POS_GAIN, `ADDR_MASK};
  localparam word_t rv [9] = '{32'h3, 32'h400, 32'h0, 32'h0, 32'h0,
    32'h50, 32'h7D0, 32'h28, 32'h0};
  localparam logic [11:0] ca [7] = '{`ADDR_WINDOW, `ADDR_BIAS,
    `ADDR_FF_AMT, `ADDR_OVF_LVL, `ADDR_SMOOTH, `ADDR_FF_FILT,
    `ADDR_COMP_GAIN};
  localparam word_t cw [7] = '{32'hFF, 32'h1F4, 32'hC8, 32'h0, 32'h2BC,
    32'h2BC, 32'hC8};
  localparam word_t cx [7] = '{32'hFA, 32'h1C2, 32'h64, 32'h1, 32'h280,
    32'h280, 32'h64};
  localparam word_t cr [7] = '{32'h3, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0,
    32'h0};
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic complete_run();
    if (err_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      complete_run();
    end
  end
  // counts cycles with a nonzero speed command, for feed-forward spikes
  always @(posedge clk_sys) begin
    if (speed_cmd != 16'sh0000) spd_hits <= spd_hits + 1;
  end
  task automatic chk_word(input word_t g, input word_t x);
    tests_run++;
    if (g !== x) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic chk_bit(input logic g, input logic x);
    tests_run++;
    if (g !== x) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input word_t d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdv = prdata;
    rerr = pslverr;
    if (n >= 50) err_count++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd_chk(input logic [11:0] a, input word_t x);
    apb(1'b0, a, 32'h0);
    chk_word(rdv, x);
  endtask
  task automatic send(input logic fb, input logic [9:0] n,
    input logic d = 1'b0);
    int k;
    k = 0;
    scnt <= n;
    sdir <= d;
    if (fb) fgo <= 1'b1;
    else cgo <= 1'b1;
    @(posedge clk_sys);
    cgo <= 1'b0;
    fgo <= 1'b0;
    repeat (2) @(posedge clk_sys);
    while ((cbusy || fbusy) && k < 5000) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 5000) err_count++;
    repeat (8) @(posedge clk_sys);
  endtask
  initial begin
    {nrst, psel, penable, pwrite, heavy_torque, cgo, fgo, sdir} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    scnt = 10'h000;
    err_count = 0;
    tests_run = 0;
    cyc = 0;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    chk_bit(in_position, 1'b1);
    for (int i = 0; i < 9; i++) rd_chk(ra[i], rv[i]);
    apb(1'b1, 12'h0FC, 32'h5);
    rd_chk(12'h0FC, 32'h0);
    chk_bit(rerr, 1'b1);
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, ca[i], cw[i]);
      rd_chk(ca[i], cx[i]);
    end
    // no smoothing: the source already shapes its profile
    for (int i = 0; i < 7; i++) apb(1'b1, ca[i], cr[i]);
    send(1'b0, 10'h003);
    chk_bit(in_position, 1'b1);
    rd_chk(`ADDR_RESIDUAL, 32'h3);
    send(1'b0, 10'h001);
    chk_bit(in_position, 1'b0);
    chk_word({16'h0, speed_cmd}, 32'h2);
    apb(1'b1, `ADDR_FF_AMT, 32'h64);
    apb(1'b1, `ADDR_BIAS, 32'hA);
    repeat (4) @(posedge clk_sys);
    chk_word({16'h0, speed_cmd}, 32'hC);
    apb(1'b1, `ADDR_BIAS, 32'h0);
    send(1'b1, 10'h004);
    chk_bit(in_position, 1'b1);
    apb(1'b1, `ADDR_MASK, 32'h1);
    send(1'b0, 10'h100);
    chk_bit(overflow_err, 1'b0);
    chk_bit(irq, 1'b0);
    send(1'b0, 10'h001);
    chk_bit(overflow_err, 1'b1);
    apb(1'b1, `ADDR_STATUS, 32'h1);
    chk_bit(irq, 1'b1);
    send(1'b1, 10'h101);
    chk_bit(overflow_err, 1'b0);
    apb(1'b1, `ADDR_STATUS, 32'h7);
    rd_chk(`ADDR_STATUS, 32'h2);
    chk_bit(irq, 1'b0);
    // feed-forward spike: one cycle per command pulse below gain 25 only
    apb(1'b1, `ADDR_POS_GAIN, 32'h18);
    hits0 = spd_hits;
    send(1'b0, 10'h002);
    chk_word(spd_hits - hits0, 32'h2);
    send(1'b1, 10'h002);
    apb(1'b1, `ADDR_POS_GAIN, 32'h19);
    hits0 = spd_hits;
    send(1'b0, 10'h002);
    chk_word(spd_hits - hits0, 32'h0);
    send(1'b1, 10'h002);
    // smoothed negative command must deliver every pulse
    apb(1'b1, `ADDR_SMOOTH, 32'h4);
    send(1'b0, 10'h008, 1'b1);
    repeat (24) @(posedge clk_sys);
    rd_chk(`ADDR_RESIDUAL, 32'hFFFF_FFF8);
    send(1'b1, 10'h008, 1'b1);
    chk_bit(in_position, 1'b1);
    rd_chk(`ADDR_RESIDUAL, 32'h0);
    apb(1'b1, `ADDR_SPD_INTEG, 32'h3E8);
    apb(1'b1, `ADDR_COMP_GAIN, 32'h28);
    heavy_torque <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk_word({21'h0, speed_gain_eff}, 32'h28);
    chk_bit(comp_gain_err, 1'b0);
    apb(1'b1, `ADDR_MASK, 32'h4);
    apb(1'b1, `ADDR_COMP_GAIN, 32'h3C);
    repeat (4) @(posedge clk_sys);
    chk_bit(comp_gain_err, 1'b1);
    chk_bit(irq, 1'b1);
    rd_chk(`ADDR_GAIN_OUT, 32'h50);
    heavy_torque <= 1'b0;
    apb(1'b1, `ADDR_COMP_GAIN, 32'h0);
    repeat (4) @(posedge clk_sys);
    chk_bit(comp_gain_err, 1'b0);
    complete_run();
  end
endmodule

// file: logic/pos_loop.sv
/*
  Position command path of a servo drive: pulse counting into an error
  counter, smoothing, feed-forward, bias, completion window, overflow,
  and speed gain reduction under torque, all set over APB.
  Assumes command pulses and feedback pulses arrive asynchronously as
  one-cycle-or-longer levels; torque flag comes from drive logic.
*/
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "pos_loop_params.svh"
module pos_loop #(
  parameter int TICK_CYC = `TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire pos_loop_pkg::word_t pwdata,
  output pos_loop_pkg::word_t prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmd_pulse,
  input wire logic cmd_dir,
  input wire logic fb_pulse,
  input wire logic fb_dir,
  input wire logic heavy_torque,
  output logic in_position,
  output logic overflow_err,
  output logic comp_gain_err,
  output logic signed [15:0] speed_cmd,
  output logic [10:0] speed_gain_eff,
  output logic irq
);
  import pos_loop_pkg::*;

  // pin synchronisers
  logic [3:0] sync1_ff, sync2_ff, prev_ff;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
      prev_ff <= 4'h0;
    end else begin
      sync1_ff <= {fb_dir, fb_pulse, cmd_dir, cmd_pulse};
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end
  logic cmd_edge, fb_edge;
  assign cmd_edge = sync2_ff[0] & ~prev_ff[0];
  assign fb_edge = sync2_ff[2] & ~prev_ff[2];

  function automatic logic [9:0] clamp_tc(input word_t v);
    clamp_tc = (v[15:0] > 16'(`MAX_TC)) ? `MAX_TC : v[9:0];
  endfunction
  function automatic logic [6:0] clamp_pct(input word_t v);
    clamp_pct = (v[15:0] > 16'(`MAX_PCT)) ? `MAX_PCT : v[6:0];
  endfunction

  // registers
  logic [7:0] window_ff, nxt_window;
  logic [8:0] bias_ff, nxt_bias;
  logic [6:0] ff_amt_ff, nxt_ff_amt, comp_ff, nxt_comp;
  logic [14:0] ovf_lvl_ff, nxt_ovf_lvl;
  logic [9:0] smooth_ff, nxt_smooth, ff_filt_ff, nxt_ff_filt;
  logic [10:0] spd_gain_ff, nxt_spd_gain;
  logic [15:0] spd_integ_ff, nxt_spd_integ;
  logic [9:0] pos_gain_ff, nxt_pos_gain;
  logic [2:0] status_ff, nxt_status, mask_ff, nxt_mask;
  word_t prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  logic [2:0] events;
  residual_t resid_ff;
  logic signed [15:0] spd_ff;
  logic [10:0] gain_ff;

  logic acc, wr;
  assign acc = psel & penable & ~pready_ff;
  assign wr = acc & pwrite;

  always_comb begin
    nxt_window = window_ff;
    nxt_bias = bias_ff;
    nxt_ff_amt = ff_amt_ff;
    nxt_ovf_lvl = ovf_lvl_ff;
    nxt_smooth = smooth_ff;
    nxt_ff_filt = ff_filt_ff;
    nxt_comp = comp_ff;
    nxt_spd_gain = spd_gain_ff;
    nxt_spd_integ = spd_integ_ff;
    nxt_pos_gain = pos_gain_ff;
    nxt_mask = mask_ff;
    nxt_status = status_ff;
    nxt_prdata = 32'h0000_0000;
    nxt_pready = acc;
    nxt_pslverr = 1'b0;
    if (wr && paddr == `ADDR_STATUS)
      nxt_status = status_ff & ~pwdata[2:0];
    nxt_status = nxt_status | events; // set wins over clear
    if (acc) begin
      if (paddr == `ADDR_WINDOW) begin
        if (wr) nxt_window = (pwdata[15:0] > 16'(`MAX_WINDOW)) ?
                             `MAX_WINDOW : pwdata[7:0];
        nxt_prdata = {24'h0, window_ff};
      end else if (paddr == `ADDR_BIAS) begin
        if (wr) nxt_bias = (pwdata[15:0] > 16'(`MAX_BIAS)) ?
                           `MAX_BIAS : pwdata[8:0];
        nxt_prdata = {23'h0, bias_ff};
      end else if (paddr == `ADDR_FF_AMT) begin
        if (wr) nxt_ff_amt = clamp_pct(pwdata);
        nxt_prdata = {25'h0, ff_amt_ff};
      end else if (paddr == `ADDR_OVF_LVL) begin
        if (wr) nxt_ovf_lvl = (pwdata[14:0] == 15'h0000) ?
                              15'h0001 : pwdata[14:0];
        nxt_prdata = {17'h0, ovf_lvl_ff};
      end else if (paddr == `ADDR_SMOOTH) begin
        if (wr) nxt_smooth = clamp_tc(pwdata);
        nxt_prdata = {22'h0, smooth_ff};
      end else if (paddr == `ADDR_FF_FILT) begin
        if (wr) nxt_ff_filt = clamp_tc(pwdata);
        nxt_prdata = {22'h0, ff_filt_ff};
      end else if (paddr == `ADDR_COMP_GAIN) begin
        if (wr) nxt_comp = clamp_pct(pwdata);
        nxt_prdata = {25'h0, comp_ff};
      end else if (paddr == `ADDR_SPD_GAIN) begin
        if (wr) nxt_spd_gain = pwdata[10:0];
        nxt_prdata = {21'h0, spd_gain_ff};
      end else if (paddr == `ADDR_SPD_INTEG) begin
        if (wr) nxt_spd_integ = pwdata[15:0];
        nxt_prdata = {16'h0, spd_integ_ff};
      end else if (paddr == `ADDR_POS_GAIN) begin
        if (wr) nxt_pos_gain = pwdata[9:0];
        nxt_prdata = {22'h0, pos_gain_ff};
      end else if (paddr == `ADDR_STATUS) begin
        nxt_prdata = {29'h0, status_ff};
      end else if (paddr == `ADDR_MASK) begin
        if (wr) nxt_mask = pwdata[2:0];
        nxt_prdata = {29'h0, mask_ff};
      end else if (paddr == `ADDR_RESIDUAL) begin
        nxt_prdata = resid_ff;
      end else if (paddr == `ADDR_SPD_OUT) begin
        nxt_prdata = {{16{spd_ff[15]}}, spd_ff};
      end else if (paddr == `ADDR_GAIN_OUT) begin
        nxt_prdata = {21'h0, gain_ff};
      end else begin
        nxt_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      window_ff <= `RST_WINDOW;
      bias_ff <= `RST_BIAS;
      ff_amt_ff <= `RST_FF_AMT;
      ovf_lvl_ff <= `RST_OVF_LVL;
      smooth_ff <= `RST_SMOOTH;
      ff_filt_ff <= `RST_FF_FILT;
      comp_ff <= `RST_COMP_GAIN;
      spd_gain_ff <= `RST_SPD_GAIN;
      spd_integ_ff <= `RST_SPD_INTEG;
      pos_gain_ff <= `RST_POS_GAIN;
      status_ff <= 3'h0;
      mask_ff <= 3'h0;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      window_ff <= nxt_window;
      bias_ff <= nxt_bias;
      ff_amt_ff <= nxt_ff_amt;
      ovf_lvl_ff <= nxt_ovf_lvl;
      smooth_ff <= nxt_smooth;
      ff_filt_ff <= nxt_ff_filt;
      comp_ff <= nxt_comp;
      spd_gain_ff <= nxt_spd_gain;
      spd_integ_ff <= nxt_spd_integ;
      pos_gain_ff <= nxt_pos_gain;
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // datapath: smoothing, error counter, feed-forward, speed, gain
  logic [15:0] tick_ff, nxt_tick;
  logic tick;
  assign tick = (tick_ff == 16'(TICK_CYC - 1));
  logic signed [31:0] pend_ff, nxt_pend;
  logic signed [31:0] ffv_ff, nxt_ffv;
  residual_t nxt_resid;
  logic signed [15:0] nxt_spd;
  logic [10:0] nxt_gain;
  logic inpos_ff, nxt_inpos, ovf_ff, nxt_ovf, cerr_ff, nxt_cerr;
  logic [15:0] comp_lim;
  logic [31:0] mag;
  logic signed [31:0] cmd_step, rate, prop, ff_in, spd_sum;

  assign comp_lim = spd_integ_ff / `COMP_LIM_DIV;
  assign events = {cerr_ff, inpos_ff, ovf_ff};

  always_comb begin
    nxt_tick = tick ? 16'h0000 : tick_ff + 16'h0001;
    cmd_step = !cmd_edge ? 32'sd0 : (sync2_ff[1] ? -32'sd1 : 32'sd1);
    // pulses gathered, then released at pend/tc per tick; same tc both
    // directions so acceleration and deceleration ramps match
    nxt_pend = pend_ff + cmd_step;
    rate = 32'sd0;
    if (smooth_ff == 10'h000)
      rate = nxt_pend;
    else if (tick) begin
      rate = pend_ff / $signed({22'h0, smooth_ff});
      // a small remainder still drains one pulse per tick, none is lost
      if (rate == 32'sd0 && pend_ff != 32'sd0)
        rate = pend_ff[31] ? -32'sd1 : 32'sd1;
    end
    nxt_pend = nxt_pend - rate;
    nxt_resid = resid_ff + rate - (!fb_edge ? 32'sd0 :
                (sync2_ff[3] ? -32'sd1 : 32'sd1));
    mag = nxt_resid[31] ? 32'(-nxt_resid) : 32'(nxt_resid);
    nxt_inpos = (mag <= {24'h0, window_ff});
    nxt_ovf = (mag > ({17'h0, ovf_lvl_ff} << `OVF_SHIFT));
    // feed-forward only below gain 25, low-passed per tick
    ff_in = (pos_gain_ff < `FF_GAIN_LIMIT) ?
            (rate * $signed({25'h0, ff_amt_ff})) : 32'sd0;
    nxt_ffv = ffv_ff;
    if (ff_filt_ff == 10'h000)
      nxt_ffv = ff_in;
    else if (tick)
      nxt_ffv = ffv_ff + (ff_in - ffv_ff) /
                $signed({22'h0, ff_filt_ff});
    prop = (resid_ff * $signed({22'h0, pos_gain_ff})) >>> 6;
    if (resid_ff > 0) prop = prop + $signed({23'h0, bias_ff});
    else if (resid_ff < 0) prop = prop - $signed({23'h0, bias_ff});
    spd_sum = prop + (ffv_ff / 32'sd100);
    if (spd_sum > 32'sd32767) nxt_spd = 16'sh7FFF;
    else if (spd_sum < -32'sd32768) nxt_spd = -16'sh8000;
    else nxt_spd = spd_sum[15:0];
    nxt_cerr = ({9'h0, comp_ff} > comp_lim);
    nxt_gain = spd_gain_ff;
    if (heavy_torque && !nxt_cerr)
      nxt_gain = (spd_gain_ff > {4'h0, comp_ff}) ?
                 spd_gain_ff - {4'h0, comp_ff} : 11'h001;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tick_ff <= 16'h0000;
      pend_ff <= 32'sd0;
      resid_ff <= 32'sd0;
      ffv_ff <= 32'sd0;
      spd_ff <= 16'sh0000;
      gain_ff <= `RST_SPD_GAIN;
      inpos_ff <= 1'b1;
      ovf_ff <= 1'b0;
      cerr_ff <= 1'b0;
      irq <= 1'b0;
    end else begin
      tick_ff <= nxt_tick;
      pend_ff <= nxt_pend;
      resid_ff <= nxt_resid;
      ffv_ff <= nxt_ffv;
      spd_ff <= nxt_spd;
      gain_ff <= nxt_gain;
      inpos_ff <= nxt_inpos;
      ovf_ff <= nxt_ovf;
      cerr_ff <= nxt_cerr;
      irq <= |(nxt_status & mask_ff);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign in_position = inpos_ff;
  assign overflow_err = ovf_ff;
  assign comp_gain_err = cerr_ff;
  assign speed_cmd = spd_ff;
  assign speed_gain_eff = gain_ff;

  a_inpos_window: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    in_position |-> ($past(mag) <= {24'h0, $past(window_ff)}) || $past(!nrst))
    else $error("in-position outside window");
  a_ovf_level: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    $rose(overflow_err) |->
    ($past(mag) > ({17'h0, $past(ovf_lvl_ff)} << `OVF_SHIFT)))
    else $error("overflow without exceeding level");
  a_ovf_sticky: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    overflow_err |=> status_ff[`ST_OVF])
    else $error("overflow status not set");
  a_gain_cut: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (heavy_torque && !nxt_cerr && spd_gain_ff > {4'h0, comp_ff}) |=>
    speed_gain_eff == $past(spd_gain_ff) - {4'h0, $past(comp_ff)})
    else $error("speed gain not reduced");
  a_comp_err: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    ({9'h0, comp_ff} > comp_lim) [*2] |-> comp_gain_err)
    else $error("compensation over limit unflagged");
  a_bias_range: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    bias_ff <= `MAX_BIAS && window_ff <= `MAX_WINDOW)
    else $error("bias or window out of range");
  a_ff_gate: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (pos_gain_ff >= `FF_GAIN_LIMIT && ff_filt_ff == 10'h000) |=> ffv_ff == 0)
    else $error("feed-forward active at high gain");
  a_smooth_pass: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (smooth_ff == 10'h000) |=> pend_ff == 0)
    else $error("smoothing held pulses at zero constant");
  a_apb_ready: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (psel && penable && !pready) |=> pready)
    else $error("apb answer late");
endmodule

// file: logic/pos_loop_params.svh
/*
  Register offsets, reset values, field limits and timing counts for the
  position command path.
  Assumes a 125 MHz system clock and a 32-bit APB register bus.
*/
// Functional notes
// - in-position output when residual within window
// - bias speed setting 0 to 450, default 0
// - feed-forward percent added straight to speed input
// - feed-forward useful only at gain below 25
// - overflow level in 256-unit steps, default 1024
// - command smoothing constant 0 to 640 tenths ms; the code counts it in ticks of 13 clocks, 104 ns each
// - acceleration ramp equals deceleration ramp
// - feed-forward low-pass constant 0 to 640 tenths ms; the code counts it in ticks of 13 clocks, 104 ns each
// - reduce speed gain by compensation under heavy torque
// - error when compensation exceeds integral-dependent limit
`ifndef POS_LOOP_PARAMS_SVH
`define POS_LOOP_PARAMS_SVH

`define ADDR_WINDOW 12'h000
`define ADDR_BIAS 12'h004
`define ADDR_FF_AMT 12'h008
`define ADDR_OVF_LVL 12'h00C
`define ADDR_SMOOTH 12'h010
`define ADDR_FF_FILT 12'h014
`define ADDR_COMP_GAIN 12'h018
`define ADDR_SPD_GAIN 12'h01C
`define ADDR_SPD_INTEG 12'h020
`define ADDR_POS_GAIN 12'h024
`define ADDR_STATUS 12'h028
`define ADDR_MASK 12'h02C
`define ADDR_RESIDUAL 12'h030
`define ADDR_SPD_OUT 12'h034
`define ADDR_GAIN_OUT 12'h038

`define RST_WINDOW 8'h03
`define MAX_WINDOW 8'hFA
`define RST_BIAS 9'h000
`define MAX_BIAS 9'h1C2
`define RST_FF_AMT 7'h00
`define MAX_PCT 7'h64
`define RST_OVF_LVL 15'h0400
`define OVF_SHIFT 8
`define RST_SMOOTH 10'h000
`define MAX_TC 10'h280
`define RST_FF_FILT 10'h000
`define RST_COMP_GAIN 7'h00
`define RST_SPD_GAIN 11'h050
`define RST_SPD_INTEG 16'h07D0
`define RST_POS_GAIN 10'h028
`define FF_GAIN_LIMIT 10'h019
// compensation limit derivation: integral constant in 0.01 ms per unit
`define COMP_LIM_DIV 16'h0014

`define TICK_NS 100
`define CLK_NS 8
`define TICK_CYCLES ((`TICK_NS + `CLK_NS - 1) / `CLK_NS)

`define ST_OVF 0
`define ST_INPOS 1
`define ST_COMP_ERR 2

`endif

// file: logic/pos_loop_pkg.sv
/*
  Types shared by the position command path.
  Assumes nothing beyond the parameter header.
*/
package pos_loop_pkg;
  typedef logic [31:0] word_t;
  typedef logic signed [31:0] residual_t;
  typedef enum logic [2:0] {
    AXIS_IDLE = 3'b001,
    AXIS_MOVE = 3'b010,
    AXIS_DONE = 3'b100
  } axis_state_t;
endpackage
